// ### rx_ptr_path_cfg.sv
// receive pointer adaptation and path termination configuration with AHB-Lite registers
// Overview of operation
// - adaptation auto AIS enable passes adaptation AIS status logic toward path stage
// - adaptation AIS force sends AIS toward path stage unconditionally
// - SS check enabled: pointer SS bits must be 10, else loss of pointer
// - 11-bit counter counts received negative pointer justifications
// - separate 11-bit counter counts received positive pointer justifications
// - write to counter high byte copies count to holding buffer and clears it
// - retiming-generated justifications do not count while retiming is enabled
// - RDI status updates after N equal G1 RDI values; select 0 means 3
// - label mismatch status updates after 3 or 5 mismatches, selected by bit
// - trace string length is 16 bytes for bit 0, 64 bytes for 1
// - path AIS force sends AIS toward path adaptation unconditionally
// - path auto AIS enable passes path AIS status logic toward adaptation
// - B3 counter counts bit errors in mode 0, block errors in mode 1
// - REI counter counts bit errors in mode 0, block errors in mode 1
// - enabled label mismatch alarm inserts RDI into transmitted G1
// - trace pulse single each frame; mode 1 doubles it every multiframe start
// - enabled unequipped alarm updates transmitted G1 RDI bits
// - B3 qualify needs 5 consecutive error-free frames for unequipped alarm
// - N1 qualify needs zero N1 in 5 consecutive frames for unequipped alarm
// - J1 qualify code 00 ignores J1, code 10 needs 5 zero J1 frames
`timescale 1ns/1ps

module rx_ptr_path_cfg
  import rx_ptr_path_pkg::*;
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // ahb-lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic       [31:0] hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // frame events and stage status
  input  frame_info_t       frame_in,
  input  wire logic         receive_retiming_disable,
  input  wire logic         adapt_alarm_signal_gen_status,
  input  wire logic         path_alarm_signal_gen_status,
  // status and control out
  output path_status_t      status_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [31:0] a);
    reg_index = a[ADDR_LSB+7:ADDR_LSB];
  endfunction : reg_index

  function automatic logic [2:0] sat_inc(input logic [2:0] v, input logic [2:0] lim);
    sat_inc = (v >= lim) ? lim : v + 3'h1;
  endfunction : sat_inc

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic       wr_pend_q, wr_pend_d;
  logic [7:0] wr_idx_q, wr_idx_d;
  logic [7:0] cfg1_q, cfg1_d;
  logic [7:0] cfg2_q, cfg2_d;
  logic [7:0] adapt_q, adapt_d;
  logic [7:0] exp_label_q, exp_label_d;
  logic [31:0] rdata_q, rdata_d;
  logic [JUST_W-1:0] neg_cnt_q, neg_cnt_d, pos_cnt_q, pos_cnt_d;
  logic [JUST_W-1:0] neg_hold_q, neg_hold_d, pos_hold_q, pos_hold_d;
  logic       addr_phase;
  logic       neg_snap, pos_snap;

  assign addr_phase = hsel && hready && htrans[1];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = rdata_q;
  assign neg_snap   = wr_pend_q && (wr_idx_q == IDX_NEG_CNT_HI);
  assign pos_snap   = wr_pend_q && (wr_idx_q == IDX_POS_CNT_HI);

  always_comb begin
    wr_pend_d   = addr_phase && hwrite;
    wr_idx_d    = addr_phase ? reg_index(haddr) : wr_idx_q;
    cfg1_d      = cfg1_q;
    cfg2_d      = cfg2_q;
    adapt_d     = adapt_q;
    exp_label_d = exp_label_q;
    rdata_d     = rdata_q;
    if (wr_pend_q) begin
      unique case (wr_idx_q)
        IDX_PATH_CFG1: cfg1_d      = hwdata[7:0] & CFG1_MASK;
        IDX_PATH_CFG2: cfg2_d      = hwdata[7:0] & CFG2_MASK;
        IDX_ADAPT_CFG: adapt_d     = hwdata[7:0] & ADAPT_MASK;
        IDX_EXP_LABEL: exp_label_d = hwdata[7:0];
        default:       ;
      endcase
    end
    if (addr_phase && !hwrite) begin
      rdata_d = '0;
      unique case (reg_index(haddr))
        IDX_PATH_CFG1:  rdata_d[7:0] = cfg1_q;
        IDX_PATH_CFG2:  rdata_d[7:0] = cfg2_q;
        IDX_ADAPT_CFG:  rdata_d[7:0] = adapt_q;
        IDX_EXP_LABEL:  rdata_d[7:0] = exp_label_q;
        IDX_NEG_CNT_LO: rdata_d[7:0] = neg_hold_q[7:0];
        IDX_NEG_CNT_HI: rdata_d[JUST_W-9:0] = neg_hold_q[JUST_W-1:8];
        IDX_POS_CNT_LO: rdata_d[7:0] = pos_hold_q[7:0];
        IDX_POS_CNT_HI: rdata_d[JUST_W-9:0] = pos_hold_q[JUST_W-1:8];
        default:        rdata_d = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // justification counters
  // ----------------------------------------------------------------
  logic neg_evt, pos_evt;

  assign neg_evt = frame_in.neg_just && !(frame_in.neg_just_retime && !receive_retiming_disable);
  assign pos_evt = frame_in.pos_just && !(frame_in.pos_just_retime && !receive_retiming_disable);

  always_comb begin
    neg_hold_d = neg_snap ? neg_cnt_q : neg_hold_q;
    pos_hold_d = pos_snap ? pos_cnt_q : pos_hold_q;
    neg_cnt_d  = neg_snap ? '0 : neg_cnt_q;
    pos_cnt_d  = pos_snap ? '0 : pos_cnt_q;
    if (neg_evt) begin
      neg_cnt_d = neg_cnt_d + JUST_W'(1);
    end
    if (pos_evt) begin
      pos_cnt_d = pos_cnt_d + JUST_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // path alarms
  // ----------------------------------------------------------------
  logic [2:0] rdi_last_q, rdi_last_d, rdi_stat_q, rdi_stat_d;
  logic [2:0] rdi_run_q, rdi_run_d;
  logic [2:0] slm_run_q, slm_run_d;
  logic       slm_q, slm_d;
  logic [2:0] b3_run_q, b3_run_d, n1_run_q, n1_run_d, j1_run_q, j1_run_d;
  logic       lop_q, lop_d;
  logic       c2_zero_q, c2_zero_d;
  logic [2:0] rdi_need, slm_need;
  logic       uneq;

  assign rdi_need = cfg1_q[CFG1_RDI_SEL] ? RDI_PERSIST_HI : RDI_PERSIST_LO;
  assign slm_need = cfg1_q[CFG1_SLM_SEL] ? SLM_COUNT_HI : SLM_COUNT_LO;
  assign uneq = c2_zero_q
              && (!cfg2_q[CFG2_B3_QUAL] || b3_run_q == UNEQ_FRAMES)
              && (!cfg2_q[CFG2_N1_QUAL] || n1_run_q == UNEQ_FRAMES)
              && ((cfg2_q[1:0] != J1_QUAL_ZERO) || j1_run_q == UNEQ_FRAMES);

  always_comb begin
    rdi_last_d = rdi_last_q;
    rdi_run_d  = rdi_run_q;
    rdi_stat_d = rdi_stat_q;
    slm_run_d  = slm_run_q;
    slm_d      = slm_q;
    b3_run_d   = b3_run_q;
    n1_run_d   = n1_run_q;
    j1_run_d   = j1_run_q;
    lop_d      = lop_q;
    c2_zero_d  = c2_zero_q;
    if (frame_in.pointer_valid) begin
      lop_d = adapt_q[ADAPT_SS_EN] && (frame_in.ss_bits != SS_EXPECTED);
    end
    if (frame_in.frame_strobe) begin
      rdi_last_d = frame_in.g1_byte[3:1];
      rdi_run_d  = (frame_in.g1_byte[3:1] == rdi_last_q) ? sat_inc(rdi_run_q, rdi_need) : 3'h1;
      if (rdi_run_d >= rdi_need) begin
        rdi_stat_d = frame_in.g1_byte[3:1];
      end
      if (frame_in.c2_byte != exp_label_q) begin
        slm_run_d = sat_inc(slm_run_q, slm_need);
        slm_d     = slm_q || (slm_run_d >= slm_need);
      end else begin
        slm_run_d = '0;
        slm_d     = 1'b0;
      end
      b3_run_d = frame_in.b3_error ? 3'h0 : sat_inc(b3_run_q, UNEQ_FRAMES);
      n1_run_d = (frame_in.n1_byte != 8'h00) ? 3'h0 : sat_inc(n1_run_q, UNEQ_FRAMES);
      j1_run_d = (frame_in.j1_byte != 8'h00) ? 3'h0 : sat_inc(j1_run_q, UNEQ_FRAMES);
      c2_zero_d = (frame_in.c2_byte == 8'h00);
    end
  end

  // ----------------------------------------------------------------
  // trace byte pulse
  // ----------------------------------------------------------------
  pulse_state_t pulse_q, pulse_d;
  logic         pulse_out;
  logic         trace_en_q, trace_en_d;

  always_comb begin
    pulse_d   = PULSE_IDLE;
    pulse_out = 1'b0;
    unique case (pulse_q)
      PULSE_IDLE: begin
        if (frame_in.j1_strobe) begin
          pulse_out = 1'b1;
          if (cfg2_q[CFG2_PULSE_SEL] && frame_in.h4_phase == MFRAME_START) begin
            pulse_d = PULSE_SECOND;
          end
        end
      end
      PULSE_SECOND: begin
        pulse_d = PULSE_IDLE;
      end
    endcase
    trace_en_d = pulse_out || (pulse_q == PULSE_SECOND);
  end

  always_comb begin
    status_out.adapt_ais = adapt_q[ADAPT_AIS_FRC]
                         || (adapt_q[ADAPT_AIS_EN] && adapt_alarm_signal_gen_status);
    status_out.path_ais  = cfg1_q[CFG1_AIS_FRC]
                         || (cfg1_q[CFG1_AIS_EN] && path_alarm_signal_gen_status);
    status_out.loss_of_pointer_alarm     = lop_q;
    status_out.path_remote_defect_status = rdi_stat_q;
    status_out.label_mismatch_alarm      = slm_q;
    status_out.path_unequipped_alarm     = uneq;
    status_out.insert_rdi = (cfg2_q[CFG2_RDI_SLM] && slm_q)
                          || (cfg2_q[CFG2_RDI_UNEQ] && uneq);
    status_out.trace_byte_enable_output  = trace_en_q;
    status_out.trace_length = cfg1_q[CFG1_TRACE_LEN] ? TRACE_LEN_HI : TRACE_LEN_LO;
    status_out.parity_increment = cfg1_q[CFG1_B3_MODE] ? {3'h0, frame_in.b3_error}
                                                       : frame_in.b3_bit_errors;
    status_out.remote_error_increment = cfg1_q[CFG1_REI_MODE]
                                      ? {3'h0, frame_in.g1_byte[7:4] != 4'h0}
                                      : frame_in.g1_byte[7:4];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q   <= 1'b0;
      wr_idx_q    <= '0;
      cfg1_q      <= CFG_RESET;
      cfg2_q      <= CFG_RESET;
      adapt_q     <= CFG_RESET;
      exp_label_q <= CFG_RESET;
      rdata_q     <= '0;
      neg_cnt_q   <= '0;
      pos_cnt_q   <= '0;
      neg_hold_q  <= '0;
      pos_hold_q  <= '0;
      rdi_last_q  <= '0;
      rdi_run_q   <= '0;
      rdi_stat_q  <= '0;
      slm_run_q   <= '0;
      slm_q       <= 1'b0;
      b3_run_q    <= '0;
      n1_run_q    <= '0;
      j1_run_q    <= '0;
      lop_q       <= 1'b0;
      c2_zero_q   <= 1'b0;
      pulse_q     <= PULSE_IDLE;
      trace_en_q  <= 1'b0;
    end else begin
      wr_pend_q   <= wr_pend_d;
      wr_idx_q    <= wr_idx_d;
      cfg1_q      <= cfg1_d;
      cfg2_q      <= cfg2_d;
      adapt_q     <= adapt_d;
      exp_label_q <= exp_label_d;
      rdata_q     <= rdata_d;
      neg_cnt_q   <= neg_cnt_d;
      pos_cnt_q   <= pos_cnt_d;
      neg_hold_q  <= neg_hold_d;
      pos_hold_q  <= pos_hold_d;
      rdi_last_q  <= rdi_last_d;
      rdi_run_q   <= rdi_run_d;
      rdi_stat_q  <= rdi_stat_d;
      slm_run_q   <= slm_run_d;
      slm_q       <= slm_d;
      b3_run_q    <= b3_run_d;
      n1_run_q    <= n1_run_d;
      j1_run_q    <= j1_run_d;
      lop_q       <= lop_d;
      c2_zero_q   <= c2_zero_d;
      pulse_q     <= pulse_d;
      trace_en_q  <= trace_en_d;
    end
  end

endmodule : rx_ptr_path_cfg

// ### rx_ptr_path_cfg_checker.sv
// concurrent checks on the receive pointer and path configuration block
`timescale 1ns/1ps

module rx_ptr_path_cfg_checker
  import rx_ptr_path_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // ahb-lite
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // frame and status
  input frame_info_t      frame_in,
  input wire logic        adapt_alarm_signal_gen_status,
  input wire logic        path_alarm_signal_gen_status,
  input path_status_t     status_out
);
  logic       wr_q;
  logic [7:0] idx_q;
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic [7:0] adapt_q;
  logic       lop_exp;

  assign lop_exp = adapt_q[ADAPT_SS_EN] && (frame_in.ss_bits != SS_EXPECTED);

  // ----------------------------------------------------------------
  // shadow of the configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b0;
      idx_q <= 8'h00;
      cfg1_q <= CFG_RESET;
      cfg2_q <= CFG_RESET;
      adapt_q <= CFG_RESET;
    end else begin
      if (hready) begin
        wr_q <= hsel && htrans[1] && hwrite;
        idx_q <= haddr[ADDR_LSB +: 8];
      end
      if (wr_q && idx_q == IDX_PATH_CFG1) cfg1_q <= hwdata[7:0] & CFG1_MASK;
      if (wr_q && idx_q == IDX_PATH_CFG2) cfg2_q <= hwdata[7:0] & CFG2_MASK;
      if (wr_q && idx_q == IDX_ADAPT_CFG) adapt_q <= hwdata[7:0] & ADAPT_MASK;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  adapt_ais_a: assert property (status_out.adapt_ais == (adapt_q[ADAPT_AIS_FRC] ||
    (adapt_q[ADAPT_AIS_EN] && adapt_alarm_signal_gen_status)))
    else $error("adaptation alarm signal wrong");
  path_ais_a: assert property (status_out.path_ais == (cfg1_q[CFG1_AIS_FRC] ||
    (cfg1_q[CFG1_AIS_EN] && path_alarm_signal_gen_status)))
    else $error("path alarm signal wrong");
  trace_len_a: assert property (status_out.trace_length ==
    (cfg1_q[CFG1_TRACE_LEN] ? TRACE_LEN_HI : TRACE_LEN_LO))
    else $error("trace length wrong");
  double_pulse_a: assert property (frame_in.j1_strobe && cfg2_q[CFG2_PULSE_SEL] &&
    frame_in.h4_phase == MFRAME_START |=> status_out.trace_byte_enable_output [*2])
    else $error("double trace pulse missing");
  single_pulse_a: assert property (frame_in.j1_strobe && !cfg2_q[CFG2_PULSE_SEL] ##1
    !frame_in.j1_strobe |-> status_out.trace_byte_enable_output ##1
    !status_out.trace_byte_enable_output)
    else $error("single trace pulse wrong");
  parity_inc_a: assert property (frame_in.frame_strobe |-> status_out.parity_increment ==
    (cfg1_q[CFG1_B3_MODE] ? {3'h0, frame_in.b3_error} : frame_in.b3_bit_errors))
    else $error("parity increment wrong");
  rei_inc_a: assert property (frame_in.frame_strobe |-> status_out.remote_error_increment ==
    (cfg1_q[CFG1_REI_MODE] ? {3'h0, |frame_in.g1_byte[7:4]} : frame_in.g1_byte[7:4]))
    else $error("remote error increment wrong");
  lop_a: assert property (frame_in.pointer_valid |=>
    status_out.loss_of_pointer_alarm == $past(lop_exp))
    else $error("loss of pointer alarm wrong");
  rdi_insert_a: assert property (status_out.insert_rdi ==
    ((cfg2_q[CFG2_RDI_SLM] && status_out.label_mismatch_alarm) ||
    (cfg2_q[CFG2_RDI_UNEQ] && status_out.path_unequipped_alarm)))
    else $error("defect insertion wrong");

  double_c: cover property (frame_in.j1_strobe && cfg2_q[CFG2_PULSE_SEL] &&
    frame_in.h4_phase == MFRAME_START);
  lop_c: cover property (status_out.loss_of_pointer_alarm);
  uneq_c: cover property (status_out.path_unequipped_alarm && status_out.insert_rdi);
  snap_c: cover property (wr_q && idx_q == IDX_NEG_CNT_HI && frame_in.neg_just);
endmodule : rx_ptr_path_cfg_checker

bind rx_ptr_path_cfg rx_ptr_path_cfg_checker chk_u (.sys_clk, .nrst, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .frame_in, .adapt_alarm_signal_gen_status,
  .path_alarm_signal_gen_status, .status_out);

// ### rx_ptr_path_pkg.sv
// constants, register map and carrier types for the receive pointer/path configuration block
package rx_ptr_path_pkg;

  // ----------------------------------------------------------------
  // register indices (byte register number, address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PATH_CFG1   = 8'h80;
  localparam logic [7:0] IDX_PATH_CFG2   = 8'h81;
  localparam logic [7:0] IDX_ADAPT_CFG   = 8'h90;
  localparam logic [7:0] IDX_NEG_CNT_LO  = 8'h91;
  localparam logic [7:0] IDX_NEG_CNT_HI  = 8'h92;
  localparam logic [7:0] IDX_POS_CNT_LO  = 8'h93;
  localparam logic [7:0] IDX_POS_CNT_HI  = 8'h94;
  localparam logic [7:0] IDX_EXP_LABEL   = 8'h82;
  localparam int         ADDR_LSB        = 2;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CFG1_RDI_SEL    = 7;
  localparam int         CFG1_SLM_SEL    = 6;
  localparam int         CFG1_TRACE_LEN  = 5;
  localparam int         CFG1_AIS_FRC    = 4;
  localparam int         CFG1_AIS_EN     = 3;
  localparam int         CFG1_B3_MODE    = 2;
  localparam int         CFG1_REI_MODE   = 1;
  localparam int         CFG2_RDI_SLM    = 6;
  localparam int         CFG2_PULSE_SEL  = 5;
  localparam int         CFG2_RDI_UNEQ   = 4;
  localparam int         CFG2_B3_QUAL    = 3;
  localparam int         CFG2_N1_QUAL    = 2;
  localparam int         ADAPT_AIS_EN    = 2;
  localparam int         ADAPT_AIS_FRC   = 1;
  localparam int         ADAPT_SS_EN     = 0;
  localparam logic [7:0] CFG1_MASK       = 8'hFE;
  localparam logic [7:0] CFG2_MASK       = 8'h7F;
  localparam logic [7:0] ADAPT_MASK      = 8'h07;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam logic [1:0] J1_QUAL_ZERO    = 2'h2;
  localparam logic [1:0] SS_EXPECTED     = 2'h2;
  localparam logic [1:0] MFRAME_START    = 2'h0;

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam int         JUST_W          = 11;
  localparam logic [2:0] RDI_PERSIST_LO  = 3'h3;
  localparam logic [2:0] RDI_PERSIST_HI  = 3'h5;
  localparam logic [2:0] SLM_COUNT_LO    = 3'h3;
  localparam logic [2:0] SLM_COUNT_HI    = 3'h5;
  localparam logic [2:0] UNEQ_FRAMES     = 3'h5;
  localparam logic [6:0] TRACE_LEN_LO    = 7'h10;
  localparam logic [6:0] TRACE_LEN_HI    = 7'h40;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       frame_strobe;
    logic       j1_strobe;
    logic       pointer_valid;
    logic [1:0] ss_bits;
    logic       neg_just;
    logic       pos_just;
    logic       neg_just_retime;
    logic       pos_just_retime;
    logic [7:0] g1_byte;
    logic [7:0] c2_byte;
    logic [7:0] n1_byte;
    logic [7:0] j1_byte;
    logic [1:0] h4_phase;
    logic       b3_error;
    logic [3:0] b3_bit_errors;
  } frame_info_t;

  typedef struct packed {
    logic       adapt_ais;
    logic       path_ais;
    logic       loss_of_pointer_alarm;
    logic [2:0] path_remote_defect_status;
    logic       label_mismatch_alarm;
    logic       path_unequipped_alarm;
    logic       insert_rdi;
    logic       trace_byte_enable_output;
    logic [6:0] trace_length;
    logic [3:0] parity_increment;
    logic [3:0] remote_error_increment;
  } path_status_t;

  typedef enum logic [1:0] {
    PULSE_IDLE   = 2'b01,
    PULSE_SECOND = 2'b10
  } pulse_state_t;

endpackage : rx_ptr_path_pkg

// ### sdh_frame_source.sv
// partner model: incoming line frame events seen by the receive block
`timescale 1ns/1ps

module sdh_frame_source
  import rx_ptr_path_pkg::*;
(
  // clock
  input  wire logic  sys_clk,
  // frame events
  output frame_info_t frame_in
);
  logic [1:0] h4_q;

  initial begin
    frame_in = '0;
    h4_q = MFRAME_START;
  end

  // ----------------------------------------------------------------
  // idle fields flip so stale bytes never look valid
  // ----------------------------------------------------------------
  function automatic frame_info_t quiet(input frame_info_t f);
    frame_info_t q;
    q = ~f;
    {q.frame_strobe, q.j1_strobe, q.pointer_valid} = 3'h0;
    {q.neg_just, q.pos_just, q.neg_just_retime, q.pos_just_retime} = 4'h0;
    return q;
  endfunction : quiet

  task automatic send_frame(input logic [7:0] c2, g1, n1, j1, input logic b3e,
                            input logic [1:0] ss);
    frame_info_t f;
    f = quiet(frame_in);
    {f.frame_strobe, f.j1_strobe, f.pointer_valid, f.ss_bits} = {3'h7, ss};
    {f.c2_byte, f.g1_byte, f.n1_byte, f.j1_byte} = {c2, g1, n1, j1};
    {f.b3_error, f.b3_bit_errors, f.h4_phase} = {b3e, 4'($urandom), h4_q};
    h4_q = h4_q + 2'h1;
    @(posedge sys_clk) frame_in <= f;
    @(posedge sys_clk) frame_in <= quiet(f);
    repeat (3) @(posedge sys_clk);
  endtask : send_frame

  task automatic send_just(input logic neg, pos, ret);
    frame_info_t f;
    f = frame_in;
    {f.neg_just, f.pos_just, f.neg_just_retime, f.pos_just_retime} = {neg, pos, neg & ret, pos & ret};
    @(posedge sys_clk) frame_in <= f;
    @(posedge sys_clk) frame_in <= quiet(f);
  endtask : send_just
endmodule : sdh_frame_source

// ### test_sdh_rx_pointer_path_config.sv
// self-checking testbench for the receive pointer and path configuration block
`timescale 1ns/1ps

module test_sdh_rx_pointer_path_config;
  import rx_ptr_path_pkg::*;
  logic         sys_clk, nrst, hsel, hwrite, hreadyout, hresp;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic         receive_retiming_disable;
  logic         adapt_alarm_signal_gen_status, path_alarm_signal_gen_status;
  frame_info_t  frame_in;
  path_status_t status_out;
  wire          hready = hreadyout;
  int           mismatches, samples_checked, neg_n, pos_n, n;
  logic [31:0]  d;
  logic [7:0]   lo;
  logic [7:0]   rw_idx [4] = '{IDX_PATH_CFG1, IDX_PATH_CFG2, IDX_EXP_LABEL, IDX_ADAPT_CFG};
  logic [7:0]   uq [6] = '{8'h18, 8'h14, 8'h12, 8'h11, 8'h13, 8'h10};

  rx_ptr_path_cfg dut_u (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .frame_in, .receive_retiming_disable,
    .adapt_alarm_signal_gen_status, .path_alarm_signal_gen_status, .status_out);
  sdh_frame_source src_u (.sys_clk, .frame_in);

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) {adapt_alarm_signal_gen_status, path_alarm_signal_gen_status} <= 2'($urandom);

  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic check_reg(input string name, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : check_reg

  task automatic check_status(input string name, input logic [7:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : check_status

  function automatic logic [31:0] mask_of(input logic [7:0] idx);
    case (idx)
      IDX_PATH_CFG1: return {24'h0, CFG1_MASK};
      IDX_PATH_CFG2: return {24'h0, CFG2_MASK};
      IDX_ADAPT_CFG: return {24'h0, ADAPT_MASK};
      IDX_EXP_LABEL: return 32'h0000_00FF;
      default:       return 32'h0;
    endcase
  endfunction : mask_of

  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hready !== 1'b1 && k < 16);
    if (hready !== 1'b1) begin
      mismatches++;
      stop_test();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 22'h0, idx, 2'h0};
    wait_ready();
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, idx, wd, x);
  endtask : wr

  task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    check_reg(name, exp, x);
  endtask : rchk

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, hsel, hwrite, htrans, haddr, hwdata, hsize} = {5'h0, 64'h0, 3'h2};
    receive_retiming_disable = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(32'h5BA4CBC6));
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) rchk("reset value", IDX_NEG_CNT_LO + 8'(i) - 8'(i / 4) * 8'h15, 32'h0);
    check_status("trace length", 8'h10, {1'b0, status_out.trace_length});
    repeat (6) begin
      for (int i = 0; i < 4; i++) begin
        d = $urandom;
        wr(rw_idx[i], d);
        rchk("register readback", rw_idx[i], d & mask_of(rw_idx[i]));
        src_u.send_frame(8'($urandom), 8'($urandom), 8'h0, 8'h1, 1'($urandom), 2'($urandom));
      end
      wr(8'hA0, $urandom);
      rchk("unmapped", 8'hA0, 32'h0);
    end
    wr(IDX_NEG_CNT_HI, 32'h0);
    wr(IDX_POS_CNT_HI, 32'h0);
    neg_n = 0;
    pos_n = 0;
    repeat (40) begin
      d = $urandom;
      receive_retiming_disable <= d[3];
      src_u.send_just(d[0], d[1], d[2] & !d[3]);
      if (!(d[2] & !d[3])) {neg_n, pos_n} = {neg_n + d[0], pos_n + d[1]};
    end
    for (int j = 0; j < 2; j++) begin
      lo = j ? IDX_POS_CNT_LO : IDX_NEG_CNT_LO;
      n = j ? pos_n : neg_n;
      wr(lo + 8'h1, $urandom);
      rchk("count low", lo, {24'h0, 8'(n)});
      rchk("count high", lo + 8'h1, {29'h0, 3'(n >> 8)});
      fork
        wr(lo + 8'h1, 32'h0);
        begin
          @(posedge sys_clk);
          src_u.send_just(j == 0, j == 1, 1'b0);
        end
      join
      rchk("count at clear", lo, 32'h0);
      wr(lo + 8'h1, 32'h0);
      rchk("count after clear", lo, 32'h1);
    end
    wr(IDX_EXP_LABEL, 32'h13);
    for (int m = 0; m < 2; m++) begin
      n = m ? 5 : 3;
      wr(IDX_PATH_CFG1, m ? 32'hC6 : 32'h00);
      wr(IDX_PATH_CFG2, m ? 32'h60 : 32'h40);
      repeat (5) src_u.send_frame(8'h13, 8'h00, 8'h55, 8'h55, 1'b0, 2'h2);
      for (int k = 1; k <= n; k++) begin
        src_u.send_frame(8'h7E, {4'($urandom), 4'hA}, 8'h55, 8'h55, 1'b1, 2'h2);
        check_status("defect status", (k == n) ? 8'h5 : 8'h0, {5'h0, status_out.path_remote_defect_status});
        check_status("label mismatch", 8'(k == n), {7'h0, status_out.label_mismatch_alarm});
      end
    end
    wr(IDX_EXP_LABEL, 32'h0);
    for (int q = 0; q < 6; q++) begin
      wr(IDX_PATH_CFG2, {24'h0, uq[q]});
      src_u.send_frame(8'h0, 8'h0, 8'h3C, 8'h3C, 1'b1, 2'h2);
      repeat (4) src_u.send_frame(8'h0, 8'h0, 8'h0, 8'h0, 1'b0, 2'h2);
      check_status("unequipped early", 8'(q > 2), {7'h0, status_out.path_unequipped_alarm});
      src_u.send_frame(8'h0, 8'h0, 8'h0, 8'h0, 1'b0, 2'h2);
      check_status("unequipped", 8'h1, {7'h0, status_out.path_unequipped_alarm});
      src_u.send_frame(8'h0, 8'h0, 8'h3C, 8'h3C, 1'b1, 2'h2);
      check_status("unequipped broken", 8'(q > 2), {7'h0, status_out.path_unequipped_alarm});
    end
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    stop_test();
  end
endmodule : test_sdh_rx_pointer_path_config
